// >>> design/asb_seq_pkg.sv
/*
  constants, transfer kinds and sequencer states for the bus-master transfer sequencer.
  assumes one bus clock shared with arbiter, decoder and slaves.
*/
// Contract
// - bus reset is active low and puts the bus outputs in a safe state.
// - granted default master in reset drives address-only, lock low, data floated; the code floats the control lines too (ctl_oe_n high in reset).
// - a non-default master in reset floats all its shared bus outputs.
// - after reset as default master keep address-only, lock low, data floated, no request.
// - then request; already granted, start strobed address-only cycle, then first fetch.
// - uncached load and fetch differ only in protection bit 0 (0 fetch, 1 data).
// - single and multiple loads, fetches and stores use word-aligned addresses.
// - uncached multiple load uses hint 00; more-words drops on the final word.
// - stores use hint 11 when buffered and 00 when unbuffered.
// - cached loads and fetches are eight-word linefills, hint 10, ascending from word 0.
// - dirty evictions cover first half, second half or whole line, ascending.
// - every eviction drives protection 11, privileged data.
// - half evictions use hint 01 at 0x00 or 0x10; whole line hint 10 from 0x00.
// - swap is one read then one write, lock asserted so the write is tied.
// - table walk is a privileged single read, hint 11, protection 10 fetch, 11 data.
// - in module test mode never master; answer only as slave when selected.
// - wrapper adds one cycle per unbuffered write and per swap read and write.
// - drain only empties the buffer; execution resumes before the last write ends.
// - never nonsequential; each access is address-only followed by sequential.
// - address strobe marks an address-only cycle followed by sequential if granted.
// - burst hint set with the strobe and held until the next transfer begins.
package asb_seq_pkg;
  localparam logic [1:0] TRAN_ADDR = 2'h0;
  localparam logic [1:0] TRAN_SEQ = 2'h3;
  localparam logic [1:0] BURST_NONE = 2'h0;
  localparam logic [1:0] BURST_4 = 2'h1;
  localparam logic [1:0] BURST_8 = 2'h2;
  localparam logic [1:0] BURST_UNDEF = 2'h3;
  localparam logic [1:0] PROT_EVICT = 2'h3;
  localparam logic [1:0] PROT_WALK_FETCH = 2'h2;
  localparam logic [1:0] PROT_WALK_DATA = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [3:0] LINE_WORDS = 4'h8;
  localparam logic [3:0] HALF_WORDS = 4'h4;
  localparam logic [3:0] ONE_WORD = 4'h1;
  localparam logic [4:0] HALF_OFS = 5'h10;
  localparam logic [31:0] WORD_STEP = 32'h4;
  localparam int RESET_MIN_CYCLES = 5;

  typedef enum logic [3:0] {
    K_FETCH = 4'h0, K_LOAD = 4'h1, K_LOAD_MULTI = 4'h2, K_STORE_BUF = 4'h3,
    K_STORE_UNBUF = 4'h4, K_FILL_INSTR = 4'h5, K_FILL_DATA = 4'h6, K_EVICT_LO = 4'h7,
    K_EVICT_HI = 4'h8, K_EVICT_ALL = 4'h9, K_SWAP = 4'hA, K_WALK_FETCH = 4'hB,
    K_WALK_DATA = 4'hC
  } kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_ADDR = 3'b010,
    ST_SEQ = 3'b011,
    ST_PEN = 3'b100
  } state_t;
endpackage : asb_seq_pkg

// >>> design/asb_master_seq.sv
/*
  bus-master transfer sequencer with slave-only test mode.
  assumes arbiter, decoder and slaves run on ref_clk; tristate pads outside resolve
  the *_oe_n enables (low = driving).
*/
module asb_master_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic test_mode,
  input wire logic ahb_mode,
  input wire logic req_valid,
  input wire asb_seq_pkg::kind_t req_kind,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_count,
  input wire logic req_priv,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic wdata_pop,
  output logic [31:0] rdata,
  output logic rdata_valid,
  output logic xfer_done,
  output logic xfer_err,
  input wire logic drain_req,
  output logic drain_ack,
  output logic areq,
  input wire logic agnt,
  input wire logic dsel,
  output logic [1:0] btran,
  output logic [31:0] ba,
  output logic bwrite,
  output logic [1:0] bsize,
  output logic [1:0] bprot,
  output logic blok,
  output logic ctl_oe_n,
  output logic [31:0] bd_out,
  output logic bd_oe_n,
  input wire logic [31:0] bd_in,
  input wire logic [1:0] btran_in,
  input wire logic bwrite_in,
  input wire logic bwait,
  input wire logic blast,
  input wire logic berror,
  output logic bwait_out,
  output logic blast_out,
  output logic berror_out,
  output logic resp_oe_n,
  output logic address_strobe,
  output logic [1:0] burst,
  output logic more_words_pending
);
  import asb_seq_pkg::*;

  state_t state, next_state;
  kind_t kind, next_kind;
  logic [31:0] addr, next_addr;
  logic [3:0] beats, next_beats;
  logic wr_phase, next_wr_phase;
  logic wr, next_wr;
  logic [1:0] prot, next_prot;
  logic [1:0] hint, next_hint;
  logic lock, next_lock;
  logic [31:0] wdata, next_wdata;
  logic [31:0] rd, next_rd;
  logic rvalid, next_rvalid;
  logic done_p, next_done_p;
  logic err_p, next_err_p;
  logic pop_p, next_pop_p;
  logic drained, next_drained;
  logic [31:0] scratch, next_scratch;
  logic slave_rd, next_slave_rd;
  logic resp_done, resp_retry, resp_err, last_beat, pen_needed;

  // slave answer decode; wait holds everything
  assign resp_done = !bwait && !berror;
  assign resp_retry = !bwait && berror && blast;
  assign resp_err = !bwait && berror && !blast;
  assign last_beat = (beats == ONE_WORD);
  assign pen_needed = ahb_mode && (kind == K_SWAP || (wr && kind == K_STORE_UNBUF));

  // bus outputs from state and held transfer registers
  assign btran = (state == ST_SEQ) ? TRAN_SEQ : TRAN_ADDR;
  assign address_strobe = (state == ST_ADDR);
  assign areq = (state != ST_IDLE) && !test_mode;
  assign ba = addr;
  assign bwrite = wr;
  assign bsize = SIZE_WORD;
  assign bprot = prot;
  assign blok = lock && (state != ST_IDLE);
  assign burst = hint;
  assign more_words_pending = (state == ST_SEQ) && (kind == K_LOAD_MULTI) && !last_beat;
  // undriven when not granted so another default master can own the lines
  assign ctl_oe_n = !agnt || test_mode || !rst_n;
  assign bd_oe_n = !((state == ST_SEQ && wr && agnt && !test_mode) || slave_rd);
  assign bd_out = slave_rd ? scratch : wdata;
  assign rdata = rd;
  assign rdata_valid = rvalid;
  assign xfer_done = done_p;
  assign xfer_err = err_p;
  assign wdata_pop = pop_p;
  assign drain_ack = drained;
  assign req_ready = (state == ST_IDLE) && !test_mode;

  // slave answer: zero-wait done whenever selected in test mode
  assign resp_oe_n = !(test_mode && dsel);
  assign bwait_out = 1'b0;
  assign blast_out = 1'b0;
  assign berror_out = 1'b0;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_addr = addr;
    next_beats = beats;
    next_wr_phase = wr_phase;
    next_wr = wr;
    next_prot = prot;
    next_hint = hint;
    next_lock = lock;
    next_wdata = wdata;
    next_rd = rd;
    next_rvalid = 1'b0;
    next_done_p = 1'b0;
    next_err_p = 1'b0;
    next_pop_p = 1'b0;
    // buffered semantics: ack next cycle, the bus may still be busy
    next_drained = drain_req;
    next_scratch = scratch;
    next_slave_rd = 1'b0;
    if (test_mode && dsel && btran_in == TRAN_SEQ) begin
      if (bwrite_in) begin
        next_scratch = bd_in;
      end else begin
        next_slave_rd = 1'b1;
      end
    end
    unique case (state)
      ST_IDLE: begin
        if (req_valid && !test_mode) begin
          next_state = ST_REQ;
          next_kind = req_kind;
          next_addr = {req_addr[31:2], 2'h0};
          next_beats = ONE_WORD;
          next_wr_phase = 1'b0;
          next_lock = 1'b0;
          next_wr = 1'b0;
          next_prot = {req_priv, 1'b1};
          next_hint = BURST_NONE;
          unique case (req_kind)
            K_FETCH: next_prot = {req_priv, 1'b0};
            K_LOAD: next_prot = {req_priv, 1'b1};
            K_LOAD_MULTI: next_beats = req_count;
            K_STORE_BUF: begin
              next_wr = 1'b1;
              next_hint = BURST_UNDEF;
              next_beats = req_count;
            end
            K_STORE_UNBUF: begin
              next_wr = 1'b1;
              next_hint = BURST_NONE;
              next_beats = req_count;
            end
            K_FILL_INSTR, K_FILL_DATA: begin
              next_addr = {req_addr[31:5], 5'h00};
              next_beats = LINE_WORDS;
              next_hint = BURST_8;
              next_prot = {req_priv, (req_kind == K_FILL_DATA)};
            end
            K_EVICT_LO, K_EVICT_HI, K_EVICT_ALL: begin
              next_wr = 1'b1;
              next_prot = PROT_EVICT;
              next_addr = {req_addr[31:5], (req_kind == K_EVICT_HI) ? HALF_OFS : 5'h00};
              next_beats = (req_kind == K_EVICT_ALL) ? LINE_WORDS : HALF_WORDS;
              next_hint = (req_kind == K_EVICT_ALL) ? BURST_8 : BURST_4;
            end
            K_SWAP: next_lock = 1'b1;
            K_WALK_FETCH: begin
              next_hint = BURST_UNDEF;
              next_prot = PROT_WALK_FETCH;
            end
            K_WALK_DATA: begin
              next_hint = BURST_UNDEF;
              next_prot = PROT_WALK_DATA;
            end
            default: next_state = ST_IDLE;
          endcase
          if (next_beats == 4'h0) begin
            next_beats = ONE_WORD;
          end
        end
      end
      ST_REQ: begin
        if (test_mode) begin
          next_state = ST_IDLE;
        end else if (agnt) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (agnt) begin
          next_state = ST_SEQ;
          if (wr) begin
            next_wdata = req_wdata;
            next_pop_p = 1'b1;
          end
        end else begin
          next_state = ST_REQ;
        end
      end
      ST_SEQ: begin
        if (resp_retry) begin
          next_state = ST_REQ;
        end else if (resp_err) begin
          next_state = ST_IDLE;
          next_err_p = 1'b1;
        end else if (resp_done) begin
          if (!wr) begin
            next_rd = bd_in;
            next_rvalid = 1'b1;
          end
          if (!last_beat) begin
            next_beats = beats - ONE_WORD;
            next_addr = addr + WORD_STEP;
            if (wr) begin
              next_wdata = req_wdata;
              next_pop_p = 1'b1;
            end
          end else if (pen_needed) begin
            next_state = ST_PEN;
          end else if (kind == K_SWAP && !wr_phase) begin
            next_state = ST_ADDR;
            next_wr_phase = 1'b1;
            next_wr = 1'b1;
          end else begin
            next_state = ST_IDLE;
            next_done_p = 1'b1;
          end
        end
      end
      ST_PEN: begin
        if (kind == K_SWAP && !wr_phase) begin
          next_state = ST_ADDR;
          next_wr_phase = 1'b1;
          next_wr = 1'b1;
        end else begin
          next_state = ST_IDLE;
          next_done_p = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // reset leaves the default-master safe state: address-only, lock low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      kind <= K_FETCH;
      addr <= 32'h0000_0000;
      beats <= 4'h1;
      wr_phase <= 1'b0;
      wr <= 1'b0;
      prot <= 2'h0;
      hint <= 2'h0;
      lock <= 1'b0;
      wdata <= 32'h0000_0000;
      rd <= 32'h0000_0000;
      rvalid <= 1'b0;
      done_p <= 1'b0;
      err_p <= 1'b0;
      pop_p <= 1'b0;
      drained <= 1'b0;
      scratch <= 32'h0000_0000;
      slave_rd <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      addr <= next_addr;
      beats <= next_beats;
      wr_phase <= next_wr_phase;
      wr <= next_wr;
      prot <= next_prot;
      hint <= next_hint;
      lock <= next_lock;
      wdata <= next_wdata;
      rd <= next_rd;
      rvalid <= next_rvalid;
      done_p <= next_done_p;
      err_p <= next_err_p;
      pop_p <= next_pop_p;
      drained <= next_drained;
      scratch <= next_scratch;
      slave_rd <= next_slave_rd;
    end
  end

  sequence s_strobe_granted;
    address_strobe && agnt;
  endsequence

  sequence s_seq_beat;
    btran == TRAN_SEQ;
  endsequence

  a_reset_safe_bus: assert property (@(posedge ref_clk)
    !rst_n |=> (btran == TRAN_ADDR && !blok && bd_oe_n && !areq))
    else $error("bus not in safe state after reset");

  a_strobe_then_seq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_granted |=> s_seq_beat)
    else $error("strobe not followed by sequential cycle");

  a_seq_after_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(btran == TRAN_SEQ) |-> $past(address_strobe))
    else $error("sequential cycle without address-only lead-in");

  a_wait_holds_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (btran == TRAN_SEQ && bwait) |=> (btran == TRAN_SEQ && $stable(ba) && $stable(bwrite)))
    else $error("transfer moved during wait");

  a_evict_prot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state != ST_IDLE && (kind == K_EVICT_LO || kind == K_EVICT_HI || kind == K_EVICT_ALL))
    |-> (bprot == 2'h3 && bwrite && burst != 2'h0))
    else $error("eviction with wrong protection or hint");

  a_word_aligned: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (btran == TRAN_SEQ) |-> (ba[1:0] == 2'h0))
    else $error("unaligned address");

  a_hint_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state != ST_IDLE && $past(state) != ST_IDLE) |-> $stable(burst))
    else $error("burst hint changed mid transfer");

  a_test_no_master: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_mode |-> (!areq && ctl_oe_n))
    else $error("bus requested in test mode");

  a_walk_encoding: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (address_strobe && kind == K_WALK_FETCH) |-> (burst == 2'h3 && bprot == 2'h2 && !bwrite))
    else $error("walk encoding wrong");

  a_mwp_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (btran == TRAN_SEQ && kind == K_LOAD_MULTI && beats == 4'h2 && resp_done)
    |=> !more_words_pending [*1])
    else $error("more-words not lowered on final word");
endmodule : asb_master_seq

// >>> testbench/asb_far_model.sv
/*
  arbiter, decoder and slave stand-in facing the transfer sequencer.
  assumes one shared ref_clk; this model is the only other party on the bus.
*/
module asb_far_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] btran,
  input wire logic [31:0] ba,
  input wire logic bwrite,
  input wire logic [1:0] wait_cycles,
  input wire logic [1:0] resp_sel,
  output logic agnt,
  output logic bwait,
  output logic blast,
  output logic berror,
  output logic [31:0] bd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  logic [31:0] last;
  logic retried;
  // no second master exists, so holding grant also honours the lock
  assign agnt = 1'b1;
  // resp_sel: 0 done, 1 error, 2 retry once and then done
  assign berror = (btran == 2'h3) && !bwait &&
    (resp_sel == 2'h1 || (resp_sel == 2'h2 && !retried));
  assign blast = berror && (resp_sel == 2'h2);
  assign bwait = (btran == 2'h3) && (cnt < wait_cycles);
  // a released data bus shows the inverse of its last value, never a stale copy
  assign bd_in = (btran == 2'h3 && !bwrite) ? (ba ^ 32'hA5A5_0000) : ~last;
  always_ff @(posedge ref_clk) begin
    last <= rst_n ? bd_in : 32'h0;
    retried <= rst_n && (resp_sel == 2'h2) && (retried || blast);
    if (!rst_n || btran != 2'h3 || !bwait) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
endmodule : asb_far_model

// >>> testbench/asb_master_transfer_sequencer_tb_top.sv
/*
  self-checking bench for the bus-master transfer sequencer.
  assumes the far side model above; the bench drives the core side and test pins.
*/
module asb_master_transfer_sequencer_tb_top;
  import asb_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, test_mode, ahb_mode, req_valid, req_priv, drain_req, dsel, bwrite_in;
  kind_t req_kind;
  logic [31:0] req_addr, req_wdata, tb_bd, m_bd, bd_in, rdata, ba, bd_out, p_ba;
  logic [3:0] req_count;
  logic [1:0] btran_in, wait_cycles, resp_sel, btran, bsize, bprot, burst, p_tran;
  logic req_ready, wdata_pop, rdata_valid, xfer_done, xfer_err, drain_ack, areq, agnt, bwrite;
  logic blok, ctl_oe_n, bd_oe_n, bwait, blast, berror, bwait_out, blast_out, berror_out;
  logic resp_oe_n, address_strobe, more_words_pending, p_strobe, p_wait;
  logic [31:0] q_addr[$];
  logic [6:0] q_attr[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int n_pop = 0;
  int n_rv = 0;

  assign bd_in = test_mode ? tb_bd : m_bd;
  asb_far_model far (.ref_clk, .rst_n, .btran, .ba, .bwrite, .wait_cycles, .resp_sel, .agnt, .bwait,
    .blast, .berror, .bd_in(m_bd));
  asb_master_seq dut (.ref_clk, .rst_n, .test_mode, .ahb_mode, .req_valid, .req_kind,
    .req_addr, .req_count, .req_priv, .req_wdata, .req_ready, .wdata_pop, .rdata,
    .rdata_valid, .xfer_done, .xfer_err, .drain_req, .drain_ack, .areq, .agnt, .dsel,
    .btran, .ba, .bwrite, .bsize, .bprot, .blok, .ctl_oe_n, .bd_out, .bd_oe_n, .bd_in,
    .btran_in, .bwrite_in, .bwait, .blast, .berror, .bwait_out, .blast_out, .berror_out,
    .resp_oe_n, .address_strobe, .burst, .more_words_pending);

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // beats are logged at the edge that completes them, from pre-edge values
  always @(posedge ref_clk) begin
    if (rst_n && !test_mode) begin
      if (btran === 2'h2) chk(32'h1, 32'h0, "nonsequential type");
      if (btran === TRAN_SEQ && p_tran !== TRAN_SEQ) chk(32'(p_strobe), 32'h1, "strobe");
      if (p_wait) chk(ba, p_ba, "address held in wait");
      if (btran === TRAN_SEQ && bwait === 1'b0 && berror === 1'b0) begin
        q_addr.push_back(ba);
        q_attr.push_back({blok, bwrite, bprot, burst, more_words_pending});
        chk(32'(bsize), 32'(SIZE_WORD), "word size");
        if (bwrite === 1'b1) begin
          chk(bd_out, ~req_addr, "write data");
          chk(32'(bd_oe_n), 32'h0, "data driven on write");
        end else begin
          chk(32'(bd_oe_n), 32'h1, "data floated on read");
        end
      end
      if (wdata_pop === 1'b1) n_pop++;
      if (rdata_valid === 1'b1) n_rv++;
    end
    p_tran = btran;
    p_strobe = address_strobe;
    p_ba = ba;
    p_wait = (btran === TRAN_SEQ) && (bwait === 1'b1);
  end

  // e packs lock, write, protection and burst hint expected on every beat but swap's, whose write bit follows the beat and hint goes unchecked
  task automatic run(input kind_t k, input logic [31:0] a, input logic [3:0] n,
      input logic [31:0] b, input logic [5:0] e, output int lat);
    logic [6:0] x, m;
    logic [31:0] ea;
    int t;
    q_addr.delete();
    q_attr.delete();
    n_pop = 0;
    n_rv = 0;
    m = (k == K_SWAP) ? 7'h79 : 7'h7F;
    ea = b;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_count <= n;
    req_wdata <= ~a;
    @(posedge ref_clk);
    chk(32'(req_ready), 32'h1, "ready");
    req_valid <= 1'b0;
    t = 0;
    while (xfer_done !== 1'b1 && t < 300) begin
      @(posedge ref_clk);
      t++;
    end
    lat = t;
    // one more edge so pulses of the closing cycle are counted
    @(posedge ref_clk);
    chk(32'(t < 300), 32'h1, "completion");
    chk(32'(q_addr.size()), 32'(k == K_SWAP ? 2 : n), "beat count");
    foreach (q_addr[i]) begin
      ea = (k == K_SWAP) ? b : b + 32'(i) * WORD_STEP;
      x = {e[5], (k == K_SWAP) ? i[0] : e[4], e[3:0], k == K_LOAD_MULTI && i != n - 1};
      chk(q_addr[i], ea, "beat address");
      chk(32'(q_attr[i] & m), 32'(x & m), "beat encoding");
    end
    if (!e[4] || k == K_SWAP) chk(rdata, (k == K_SWAP ? b : ea) ^ 32'hA5A5_0000, "read data");
    chk(32'(n_pop), (k == K_SWAP) ? 32'h1 : (e[4] ? 32'(n) : 32'h0), "write pops");
    chk(32'(n_rv), (k == K_SWAP) ? 32'h1 : (e[4] ? 32'h0 : 32'(n)), "read strobes");
  endtask : run

  initial begin
    #3_000_000;
    chk(32'h1, 32'h0, "watchdog expired");
    results();
  end

  initial begin
    int lat0[13];
    int lt;
    kind_t k;
    logic [31:0] a, b;
    logic [3:0] n;
    logic [5:0] e;
    rst_n = 1'b0;
    {test_mode, ahb_mode, req_valid, req_priv, drain_req, dsel, bwrite_in} = 7'h00;
    req_kind = K_FETCH;
    {req_addr, req_wdata, tb_bd} = {3{32'h0}};
    req_count = 4'h0;
    btran_in = 2'h0;
    wait_cycles = 2'h0;
    resp_sel = 2'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk(32'({btran, blok, bd_oe_n, areq, ctl_oe_n}), 32'h05, "reset outputs");
    repeat (7) @(posedge ref_clk);
    // release in the low phase so the next sampling edge sees a settled level
    @(negedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(32'({areq, btran, blok, bd_oe_n}), 32'h01, "idle default master");
    @(posedge ref_clk);
    // pass 0 plain, pass 1 wrapper penalties, pass 2 slave wait states
    for (int p = 0; p < 3; p++) begin
      ahb_mode <= (p == 1);
      req_priv <= (p == 1);
      wait_cycles <= (p == 2) ? 2'h2 : 2'h0;
      for (int i = 0; i < 13; i++) begin
        k = kind_t'(i);
        a = 32'h100;
        b = 32'h100;
        n = 4'h1;
        case (k)
          K_FETCH: begin a = 32'h108; b = a; e = 6'h00; end
          K_LOAD: begin a = 32'h108; b = a; e = 6'h04; end
          K_LOAD_MULTI: begin a = 32'h108; b = a; n = 4'h5; e = 6'h04; end
          K_STORE_BUF: begin a = 32'h200; b = a; n = 4'h2; e = 6'h17; end
          K_STORE_UNBUF: begin a = 32'h200; b = a; e = 6'h14; end
          K_FILL_INSTR: begin a = 32'h104; n = 4'h8; e = 6'h02; end
          K_FILL_DATA: begin a = 32'h11C; n = 4'h8; e = 6'h06; end
          K_EVICT_LO: begin n = 4'h4; e = 6'h1D; end
          K_EVICT_HI: begin b = 32'h110; n = 4'h4; e = 6'h1D; end
          K_EVICT_ALL: begin n = 4'h8; e = 6'h1E; end
          K_SWAP: begin a = 32'h300; b = a; e = 6'h24; end
          K_WALK_FETCH: begin a = 32'h104; b = a; e = 6'h0B; end
          default: begin a = 32'h104; b = a; e = 6'h0F; end
        endcase
        // privileged pass: protection bit 1 follows the request; evictions and walks have it fixed
        if (p == 1) e = e | 6'h08;
        run(k, a, n, b, e, lt);
        if (p == 0) lat0[i] = lt;
        if (p == 1) chk(32'(lt - lat0[i]), (k == K_SWAP) ? 32'h2 : 32'(k == K_STORE_UNBUF), "penalty");
      end
    end
    wait_cycles <= 2'h0;
    resp_sel <= 2'h2;
    run(K_LOAD, 32'h108, 4'h1, 32'h108, 6'h04, lt);
    chk(32'(lt - lat0[1]), 32'h3, "retry cost");
    resp_sel <= 2'h1;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind <= K_LOAD;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(32'({xfer_err, xfer_done, req_ready}), 32'h5, "error ends transfer");
    @(posedge ref_clk);
    resp_sel <= 2'h0;
    drain_req <= 1'b1;
    @(posedge ref_clk);
    drain_req <= 1'b0;
    #1 chk(32'(drain_ack), 32'h1, "drain answered without bus");
    @(posedge ref_clk);
    test_mode <= 1'b1;
    dsel <= 1'b1;
    btran_in <= 2'h3;
    bwrite_in <= 1'b1;
    tb_bd <= 32'h5A5A_1234;
    @(posedge ref_clk);
    bwrite_in <= 1'b0;
    tb_bd <= ~32'h5A5A_1234;
    #1 chk(32'({req_ready, areq, ctl_oe_n, resp_oe_n}), 32'h2, "slave only");
    @(posedge ref_clk);
    btran_in <= 2'h0;
    #1 chk(bd_out, 32'h5A5A_1234, "slave read data");
    chk(32'({bd_oe_n, bwait_out, blast_out, berror_out}), 32'h0, "slave drive");
    results();
  end
endmodule : asb_master_transfer_sequencer_tb_top
